// ==== inc/lid_regs.vh ====
`ifndef LID_REGS_VH
`define LID_REGS_VH

// host instruction byte fields
`define LID_BIT_TEXT_ADDR   7
`define LID_BIT_GLYPH_ADDR  6
`define LID_BIT_FUNC_SET    5
`define LID_BIT_SHIFT       4
`define LID_BIT_DISP_CTRL   3
`define LID_BIT_ENTRY       2
`define LID_BIT_HOME        1
`define LID_BIT_CLEAR       0
`define LID_BIT_DISP_ON     2
`define LID_BIT_CURSOR_ON   1
`define LID_BIT_BLINK       0
`define LID_BIT_STEP_INC    1
`define LID_BIT_AUTO_SCROLL 0
`define LID_BIT_BUSY        7

// widths and constants
`define LID_AC_W            7
`define LID_GLYPH_AW        5
`define LID_GLYPH_DW        5
`define LID_TEXT_AW         4
`define LID_TEXT_DEPTH      16
`define LID_GLYPH_DEPTH     32
`define LID_CNT_W           18
`define LID_SPACE_CODE      8'h20
`define LID_ZERO_BYTE       8'h00
`define LID_AC_HOME         7'h00
`define LID_SHIFT_HOME      4'h0
`define LID_SHIFT_ONE       4'h1
`define LID_FILL_LAST       4'hf
`define LID_CNT_ONE         18'h0_0001

// execution times at the nominal oscillator rate
`define LID_T_ADDR_NS       37000
`define LID_T_WRITE_NS      37000
`define LID_T_READ_NS       56000
`define LID_T_CLEAR_NS      1520000
`define LID_OSC_NOM_KHZ     270
`define LID_CLK_NS          10

`endif

// ==== hw/lid_exec_timer.v ====
`timescale 1ns/1ns
`include "lid_regs.vh"

module lid_exec_timer (
    input  wire                  clock,
    input  wire                  rstn,
    input  wire                  start,
    input  wire [`LID_CNT_W-1:0] cycles,
    output reg                   busy_q
);

    reg [`LID_CNT_W-1:0] count_q;

    // busy stays high for exactly the loaded number of cycles
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_q  <= 1'b0;
            count_q <= {`LID_CNT_W{1'b0}};
        end else if (start) begin
            busy_q  <= 1'b1;
            count_q <= cycles - `LID_CNT_ONE;
        end else if (busy_q) begin
            if (count_q == {`LID_CNT_W{1'b0}}) begin
                busy_q <= 1'b0;
            end else begin
                count_q <= count_q - `LID_CNT_ONE;
            end
        end
    end

endmodule

// ==== hw/lid_decoder.v ====
// Overview of operation
// - top bit set loads text memory pointer
// - status read returns busy and address counter
// - busy reads one while executing; host waits
// - data write goes to last addressed memory
// - data read comes from addressed memory
// - one address counter serves both memories
// - zero code in 4-bit enters test mode
// - zero code in 8-bit does nothing
// - clear fills text memory with spaces
// - clear homes counter, forces increment, keeps scroll
// - home resets counter and shift, keeps text
// - entry mode stores direction and auto scroll
// - counter steps up or down after access
// - auto scroll shifts display on text writes
// - no shift on text reads or glyph access
// - display control sets screen, cursor, blink
// - clear takes far longer than others
// - execution times scale with oscillator rate
`timescale 1ns/1ns
`include "lid_regs.vh"

module lid_decoder #(
    parameter integer osc_khz     = `LID_OSC_NOM_KHZ,
    parameter integer read_cycles =
        (`LID_T_READ_NS * `LID_OSC_NOM_KHZ + osc_khz * `LID_CLK_NS - 1)
        / (osc_khz * `LID_CLK_NS),
    parameter integer clear_cycles =
        (`LID_T_CLEAR_NS * `LID_OSC_NOM_KHZ + osc_khz * `LID_CLK_NS - 1)
        / (osc_khz * `LID_CLK_NS)
) (
    input  wire                  clock,
    input  wire                  rstn,
    input  wire                  register_select,
    input  wire                  read_write,
    input  wire                  enable,
    input  wire [7:0]            host_bus_line_in,
    input  wire                  interface_8bit,
    output reg  [7:0]            host_bus_line_out_q,
    output reg                   host_bus_line_oe_q,
    output wire                  busy_indicator,
    output reg  [`LID_AC_W-1:0]  address_counter_q,
    output reg                   target_glyph_q,
    output reg                   display_on_q,
    output reg                   cursor_on_q,
    output reg                   cursor_blink_q,
    output reg                   step_increment_q,
    output reg                   auto_scroll_q,
    output reg  [3:0]            display_shift_q,
    output reg                   test_mode_q
);

    // execution counts, scaled from the nominal oscillator rate
    localparam integer ADDR_CYC =
        (`LID_T_ADDR_NS * `LID_OSC_NOM_KHZ + osc_khz * `LID_CLK_NS - 1)
        / (osc_khz * `LID_CLK_NS);
    localparam integer WRITE_CYC =
        (`LID_T_WRITE_NS * `LID_OSC_NOM_KHZ + osc_khz * `LID_CLK_NS - 1)
        / (osc_khz * `LID_CLK_NS);
    localparam [`LID_CNT_W-1:0] ADDR_CNT  = ADDR_CYC[`LID_CNT_W-1:0];
    localparam [`LID_CNT_W-1:0] WRITE_CNT = WRITE_CYC[`LID_CNT_W-1:0];
    localparam [`LID_CNT_W-1:0] READ_CNT  = read_cycles[`LID_CNT_W-1:0];
    localparam [`LID_CNT_W-1:0] CLEAR_CNT = clear_cycles[`LID_CNT_W-1:0];

    // pin synchronisers; logic reads the second stage, plus the third enable stage for edge detection
    reg                  en_s1_q;
    reg                  en_s2_q;
    reg                  en_s3_q;
    reg                  rs_s1_q;
    reg                  rs_s2_q;
    reg                  rw_s1_q;
    reg                  rw_s2_q;
    reg  [7:0]           db_s1_q;
    reg  [7:0]           db_s2_q;

    reg                  phase_q;
    reg  [3:0]           high_nib_q;
    reg                  fill_act_q;
    reg  [3:0]           fill_idx_q;
    reg                  start_q;
    reg  [`LID_CNT_W-1:0] cycles_q;

    reg  [7:0]           text_mem [0:`LID_TEXT_DEPTH-1];
    reg  [`LID_GLYPH_DW-1:0] glyph_mem [0:`LID_GLYPH_DEPTH-1];

    wire                 en_fall;
    wire                 en_rise;
    wire                 byte_done;
    wire [7:0]           host_byte;
    wire [7:0]           mem_byte;
    wire [7:0]           status_byte;
    wire [7:0]           read_byte;
    wire                 is_status;
    wire                 is_cmd;
    wire                 is_wdata;
    wire                 is_rdata;
    wire                 accept;
    wire                 text_write;

    // one step of the shared counter; glyph addresses wrap in their own range
    function [`LID_AC_W-1:0] step_addr;
        input [`LID_AC_W-1:0] addr;
        input                 inc;
        input                 glyph;
        reg   [`LID_AC_W-1:0] nxt;
        begin
            nxt = inc ? addr + `LID_AC_W'd1 : addr - `LID_AC_W'd1;
            if (glyph) begin
                step_addr = {2'b00, nxt[`LID_GLYPH_AW-1:0]};
            end else begin
                step_addr = nxt;
            end
        end
    endfunction

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            en_s3_q <= 1'b0;
            rs_s1_q <= 1'b0;
            rs_s2_q <= 1'b0;
            rw_s1_q <= 1'b0;
            rw_s2_q <= 1'b0;
            db_s1_q <= 8'h00;
            db_s2_q <= 8'h00;
        end else begin
            en_s1_q <= enable;
            en_s2_q <= en_s1_q;
            en_s3_q <= en_s2_q;
            rs_s1_q <= register_select;
            rs_s2_q <= rs_s1_q;
            rw_s1_q <= read_write;
            rw_s2_q <= rw_s1_q;
            db_s1_q <= host_bus_line_in;
            db_s2_q <= db_s1_q;
        end
    end

    // transfers are taken on the falling edge of the strobe
    assign en_fall   = en_s3_q & ~en_s2_q;
    assign en_rise   = en_s2_q & ~en_s3_q;
    assign byte_done = en_fall & (interface_8bit | phase_q);
    assign host_byte = interface_8bit ? db_s2_q : {high_nib_q, db_s2_q[7:4]};

    assign is_status = ~rs_s2_q & rw_s2_q;
    assign is_cmd    = ~rs_s2_q & ~rw_s2_q;
    assign is_wdata  = rs_s2_q & ~rw_s2_q;
    assign is_rdata  = rs_s2_q & rw_s2_q;
    // anything but a status read is dropped while busy
    assign accept    = byte_done & ~busy_indicator & ~is_status;
    assign text_write = accept & is_wdata & ~target_glyph_q;

    assign mem_byte = target_glyph_q ?
                      {3'b000, glyph_mem[address_counter_q[`LID_GLYPH_AW-1:0]]} :
                      text_mem[address_counter_q[`LID_TEXT_AW-1:0]];
    assign status_byte = {busy_indicator, address_counter_q};
    assign read_byte   = rs_s2_q ? mem_byte : status_byte;

    // nibble phase: high nibble first, both reads and writes
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_q    <= 1'b0;
            high_nib_q <= 4'h0;
        end else if (interface_8bit) begin
            phase_q <= 1'b0;
        end else if (en_fall) begin
            phase_q <= ~phase_q;
            if (!phase_q) begin
                high_nib_q <= db_s2_q[7:4];
            end
        end
    end

    // read drive: byte or nibble presented from strobe rise
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            host_bus_line_out_q <= 8'h00;
            host_bus_line_oe_q  <= 1'b0;
        end else begin
            host_bus_line_oe_q <= en_s2_q & rw_s2_q;
            if (en_rise && rw_s2_q) begin
                if (interface_8bit) begin
                    host_bus_line_out_q <= read_byte;
                end else if (!phase_q) begin
                    host_bus_line_out_q <= {read_byte[7:4], 4'h0};
                end else begin
                    host_bus_line_out_q <= {read_byte[3:0], 4'h0};
                end
            end
        end
    end

    // text memory: clear walks one location per clock under busy
    always @(posedge clock) begin
        if (fill_act_q) begin
            text_mem[fill_idx_q] <= `LID_SPACE_CODE;
        end else if (text_write) begin
            text_mem[address_counter_q[`LID_TEXT_AW-1:0]] <= host_byte;
        end
    end

    // glyph memory keeps the low five bits of each written byte
    always @(posedge clock) begin
        if (accept && is_wdata && target_glyph_q) begin
            glyph_mem[address_counter_q[`LID_GLYPH_AW-1:0]] <=
                host_byte[`LID_GLYPH_DW-1:0];
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fill_act_q <= 1'b0;
            fill_idx_q <= 4'h0;
        end else if (accept && is_cmd && host_byte[`LID_BIT_CLEAR] &&
                     host_byte[7:1] == 7'h00) begin
            fill_act_q <= 1'b1;
            fill_idx_q <= 4'h0;
        end else if (fill_act_q) begin
            fill_idx_q <= fill_idx_q + 4'h1;
            if (fill_idx_q == `LID_FILL_LAST) begin
                fill_act_q <= 1'b0;
            end
        end
    end

    // instruction and data execution
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            address_counter_q <= `LID_AC_HOME;
            target_glyph_q    <= 1'b0;
            display_on_q      <= 1'b0;
            cursor_on_q       <= 1'b0;
            cursor_blink_q    <= 1'b0;
            step_increment_q  <= 1'b1;
            auto_scroll_q     <= 1'b0;
            display_shift_q   <= `LID_SHIFT_HOME;
            test_mode_q       <= 1'b0;
            start_q           <= 1'b0;
            cycles_q          <= {`LID_CNT_W{1'b0}};
        end else begin
            start_q <= 1'b0;
            if (accept && is_wdata) begin
                address_counter_q <= step_addr(address_counter_q, step_increment_q,
                                               target_glyph_q);
                if (auto_scroll_q && !target_glyph_q) begin
                    // shift opposes the cursor step so the cursor looks still
                    display_shift_q <= step_increment_q ?
                        display_shift_q - `LID_SHIFT_ONE :
                        display_shift_q + `LID_SHIFT_ONE;
                end
                start_q  <= 1'b1;
                cycles_q <= WRITE_CNT;
            end else if (accept && is_rdata) begin
                // reads step the counter but never scroll
                address_counter_q <= step_addr(address_counter_q, step_increment_q,
                                               target_glyph_q);
                start_q  <= 1'b1;
                cycles_q <= READ_CNT;
            end else if (accept && is_cmd) begin
                if (host_byte[`LID_BIT_TEXT_ADDR]) begin
                    address_counter_q <= host_byte[`LID_AC_W-1:0];
                    target_glyph_q    <= 1'b0;
                    start_q  <= 1'b1;
                    cycles_q <= ADDR_CNT;
                end else if (host_byte[`LID_BIT_GLYPH_ADDR]) begin
                    address_counter_q <= {2'b00, host_byte[`LID_GLYPH_AW-1:0]};
                    target_glyph_q    <= 1'b1;
                    start_q  <= 1'b1;
                    cycles_q <= ADDR_CNT;
                end else if (host_byte[`LID_BIT_FUNC_SET] ||
                             host_byte[`LID_BIT_SHIFT]) begin
                    // handled elsewhere; only the busy time is kept here
                    start_q  <= 1'b1;
                    cycles_q <= READ_CNT;
                end else if (host_byte[`LID_BIT_DISP_CTRL]) begin
                    display_on_q   <= host_byte[`LID_BIT_DISP_ON];
                    cursor_on_q    <= host_byte[`LID_BIT_CURSOR_ON];
                    cursor_blink_q <= host_byte[`LID_BIT_BLINK];
                    start_q  <= 1'b1;
                    cycles_q <= ADDR_CNT;
                end else if (host_byte[`LID_BIT_ENTRY]) begin
                    step_increment_q <= host_byte[`LID_BIT_STEP_INC];
                    auto_scroll_q    <= host_byte[`LID_BIT_AUTO_SCROLL];
                    start_q  <= 1'b1;
                    cycles_q <= ADDR_CNT;
                end else if (host_byte[`LID_BIT_HOME]) begin
                    address_counter_q <= `LID_AC_HOME;
                    target_glyph_q    <= 1'b0;
                    display_shift_q   <= `LID_SHIFT_HOME;
                    start_q  <= 1'b1;
                    cycles_q <= ADDR_CNT;
                end else if (host_byte[`LID_BIT_CLEAR]) begin
                    address_counter_q <= `LID_AC_HOME;
                    target_glyph_q    <= 1'b0;
                    step_increment_q  <= 1'b1;
                    display_shift_q   <= `LID_SHIFT_HOME;
                    start_q  <= 1'b1;
                    cycles_q <= CLEAR_CNT;
                end else if (host_byte == `LID_ZERO_BYTE) begin
                    // host is expected never to send this in 4-bit mode
                    if (!interface_8bit) begin
                        test_mode_q <= 1'b1;
                    end
                    // 8-bit: no state changes and no busy time
                end
            end
        end
    end

    // busy starts one clock after acceptance, released by the timer
    lid_exec_timer u_timer (
        .clock  (clock),
        .rstn   (rstn),
        .start  (start_q),
        .cycles (cycles_q),
        .busy_q (busy_indicator)
    );

endmodule

// ==== verification/lid_chk.sv ====
`timescale 1ns/1ns
`include "lid_regs.vh"

module lid_chk #(
    parameter integer osc_khz      = 270,
    parameter integer read_cycles  = 5600,
    parameter integer clear_cycles = 152000
) (
    input wire                 clock,
    input wire                 rstn,
    input wire                 read_write,
    input wire                 enable,
    input wire                 interface_8bit,
    input wire [7:0]           host_bus_line_out_q,
    input wire                 host_bus_line_oe_q,
    input wire                 busy_indicator,
    input wire [`LID_AC_W-1:0] address_counter_q,
    input wire                 step_increment_q,
    input wire                 auto_scroll_q,
    input wire [3:0]           display_shift_q,
    input wire                 test_mode_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    reg [17:0] run_q;

    // busy run length, so the longest run is bounded without a huge repetition
    always @(posedge clock or negedge rstn) begin
        if (!rstn)
            run_q <= 18'h0_0000;
        else if (busy_indicator)
            run_q <= run_q + 18'h0_0001;
        else
            run_q <= 18'h0_0000;
    end

    a_busy_min_run: assert property ($rose(busy_indicator) |-> busy_indicator [*8])
        else $error("busy run too short");
    a_busy_run_bound: assert property (run_q <= clear_cycles)
        else $error("busy run too long");
    a_counter_starts_busy: assert property ($changed(address_counter_q) |=> $rose(busy_indicator))
        else $error("counter moved without busy time");
    a_hold_while_busy: assert property (busy_indicator && $past(busy_indicator) |->
        $stable(address_counter_q) && $stable(step_increment_q) && $stable(auto_scroll_q))
        else $error("state changed while busy");
    a_shift_needs_scroll: assert property ($changed(display_shift_q) && display_shift_q != 4'h0
        |-> auto_scroll_q && display_shift_q == (step_increment_q ?
        $past(display_shift_q) - 4'h1 : $past(display_shift_q) + 4'h1))
        else $error("display shift step wrong");
    a_oe_after_read: assert property (host_bus_line_oe_q |-> $past(read_write, 3) && $past(enable, 3))
        else $error("bus driven outside a read");
    a_test_only_4bit: assert property ($rose(test_mode_q) |-> !interface_8bit)
        else $error("test mode entered in 8-bit length");
    a_test_sticky: assert property (test_mode_q |=> test_mode_q)
        else $error("test mode dropped");
    a_nibble_low_zero: assert property (host_bus_line_oe_q && !interface_8bit
        |-> host_bus_line_out_q[3:0] == 4'h0)
        else $error("low nibble driven in 4-bit length");

    c_test_mode: cover property ($rose(test_mode_q));
    c_long_busy: cover property ($fell(busy_indicator) && run_q > 18'h0_0040);
    c_scroll: cover property ($changed(display_shift_q));
    c_nibble_read: cover property (host_bus_line_oe_q && !interface_8bit);
endmodule

bind lid_decoder lid_chk #(
    .osc_khz(osc_khz), .read_cycles(read_cycles), .clear_cycles(clear_cycles)
) u_chk (
    .clock(clock), .rstn(rstn), .read_write(read_write), .enable(enable),
    .interface_8bit(interface_8bit), .host_bus_line_out_q(host_bus_line_out_q),
    .host_bus_line_oe_q(host_bus_line_oe_q), .busy_indicator(busy_indicator),
    .address_counter_q(address_counter_q), .step_increment_q(step_increment_q),
    .auto_scroll_q(auto_scroll_q), .display_shift_q(display_shift_q),
    .test_mode_q(test_mode_q)
);

// ==== verification/lid_host_model.sv ====
`timescale 1ns/1ns

module lid_host_model (
    input  wire       clock,
    input  wire       is_8bit,
    input  wire [7:0] rd_data,
    output reg        rs,
    output reg        rw,
    output reg        en,
    output reg  [7:0] bus
);
    integer gap;

    // idle bus is nonzero so a power-on glitch never reads as a zero code
    initial begin
        gap = 4;
        rs = 1'b0;
        rw = 1'b0;
        en = 1'b0;
        bus = 8'hff;
    end

    // one strobe; gap sets setup, width and hold, so the host can be slow
    task xfer(input r_s, input r_w, input [7:0] dd, output [7:0] qq);
        begin
            @(posedge clock);
            #1 rs = r_s;
            rw = r_w;
            bus = dd;
            repeat (gap) @(posedge clock);
            #1 en = 1'b1;
            repeat (gap) @(posedge clock);
            qq = rd_data;
            #1 en = 1'b0;
            repeat (gap) @(posedge clock);
            #1 bus = ~dd;
        end
    endtask

    // a byte is one transfer, or high nibble then low nibble
    task host_io(input r_s, input r_w, input [7:0] dd, output [7:0] qq);
        reg [7:0] hi;
        reg [7:0] lo;
        begin
            if (is_8bit) begin
                xfer(r_s, r_w, dd, qq);
            end else begin
                xfer(r_s, r_w, {dd[7:4], 4'h0}, hi);
                xfer(r_s, r_w, {dd[3:0], 4'h0}, lo);
                qq = {hi[7:4], lo[7:4]};
            end
        end
    endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ns
`include "lid_regs.vh"

module tb;
    localparam integer OSC = 27000;
    localparam integer DIV = OSC * 10;
    localparam integer T_A = (`LID_T_ADDR_NS * `LID_OSC_NOM_KHZ + DIV - 1) / DIV;
    localparam integer T_R = (`LID_T_READ_NS * `LID_OSC_NOM_KHZ + DIV - 1) / DIV;
    localparam integer T_C = (`LID_T_CLEAR_NS * `LID_OSC_NOM_KHZ + DIV - 1) / DIV;
    reg        clock;
    reg        rstn;
    reg        is8;
    wire       rs;
    wire       rw;
    wire       en;
    wire [7:0] hbus;
    wire [7:0] dout;
    wire       oe;
    wire       busy;
    wire [6:0] ac;
    wire       glyph;
    wire       don;
    wire       con;
    wire       bon;
    wire       inc;
    wire       scr;
    wire [3:0] shift;
    wire       tmode;
    wire [7:0] line;
    integer    error_cnt;
    integer    checks;
    integer    run_cnt;
    integer    last_run;
    integer    i;
    integer    m;
    reg [31:0] seed;
    reg [6:0]  e_ac;
    reg        e_inc;
    reg        e_scr;
    reg [3:0]  e_sh;
    reg [6:0]  a;
    reg [6:0]  ta;
    reg [7:0]  d;
    reg [7:0]  q;
    reg [7:0]  mem [0:15];

    assign line = oe ? dout : hbus;

    lid_decoder #(.osc_khz(OSC)) dut (
        .clock(clock), .rstn(rstn), .register_select(rs), .read_write(rw), .enable(en),
        .host_bus_line_in(line), .interface_8bit(is8), .host_bus_line_out_q(dout),
        .host_bus_line_oe_q(oe), .busy_indicator(busy), .address_counter_q(ac),
        .target_glyph_q(glyph), .display_on_q(don), .cursor_on_q(con),
        .cursor_blink_q(bon), .step_increment_q(inc), .auto_scroll_q(scr),
        .display_shift_q(shift), .test_mode_q(tmode)
    );

    lid_host_model host (
        .clock(clock), .is_8bit(is8), .rd_data(line), .rs(rs), .rw(rw), .en(en), .bus(hbus)
    );

    always #5 clock = ~clock;

    // length of the last busy run, read back once the host sees idle
    always @(posedge clock) begin
        if (busy === 1'b1) begin
            run_cnt <= run_cnt + 1;
        end else if (run_cnt != 0) begin
            last_run <= run_cnt;
            run_cnt <= 0;
        end
    end

    function [6:0] nxt_ac(input [6:0] v, input up);
        nxt_ac = up ? v + 7'h01 : v - 7'h01;
    endfunction

    function [3:0] nxt_sh(input [3:0] v, input up, input s);
        nxt_sh = !s ? v : (up ? v - 4'h1 : v + 4'h1);
    endfunction

    task chk(input [8*10-1:0] name, input [15:0] exp, input [15:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0s exp %h got %h", name, exp, got);
            end
        end
    endtask

    task op(input r_s, input r_w, input [7:0] dd);
        begin
            host.host_io(r_s, r_w, dd, q);
            repeat (2) @(posedge clock);
        end
    endtask

    // poll status until idle, then compare counter and busy length
    task idle(input integer n);
        integer k;
        begin
            chk("busy_on", n != 0, busy);
            k = 0;
            q = 8'h80;
            while (q[7] !== 1'b0 && k < 300) begin
                op(1'b0, 1'b1, 8'h00);
                k = k + 1;
            end
            chk("status", {1'b0, e_ac}, q);
            if (n != 0)
                chk("busy_len", n, last_run);
        end
    endtask

    task end_sim;
        begin
            $display("checks %0d errors %0d", checks, error_cnt);
            if (error_cnt == 0 && checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // cut a hang: the whole run needs well under a third of this span
    initial begin
        #600000;
        error_cnt = error_cnt + 1;
        end_sim;
    end

    initial begin
        seed = 32'h6e57fe1d;
        error_cnt = 0;
        checks = 0;
        run_cnt = 0;
        last_run = 0;
        e_ac = 7'h00;
        e_sh = 4'h0;
        clock = 1'b0;
        rstn = 1'b0;
        is8 = 1'b1;
        repeat (5) @(posedge clock);
        #1 rstn = 1'b1;
        chk("reset", 16'h0001, {shift, ac, busy, glyph, scr, oe, inc});
        // every entry mode: write three, read them back
        for (m = 0; m < 4; m = m + 1) begin
            e_inc = m[1];
            e_scr = m[0];
            op(1'b0, 1'b0, 8'h04 | m[7:0]);
            idle(T_A);
            chk("entry", {e_inc, e_scr}, {inc, scr});
            ta = 7'h04 + ($random(seed) & 7'h07);
            e_ac = ta;
            op(1'b0, 1'b0, {1'b1, ta});
            idle(T_A);
            chk("glyph_sel", 16'h0000, glyph);
            for (i = 0; i < 3; i = i + 1) begin
                d = $random(seed);
                mem[e_ac[3:0]] = d;
                e_ac = nxt_ac(e_ac, e_inc);
                e_sh = nxt_sh(e_sh, e_inc, e_scr);
                op(1'b1, 1'b0, d);
                idle(T_A);
                chk("shift", e_sh, shift);
            end
            e_ac = ta;
            op(1'b0, 1'b0, {1'b1, ta});
            idle(T_A);
            for (i = 0; i < 3; i = i + 1) begin
                op(1'b1, 1'b1, 8'h00);
                chk("rd_text", mem[e_ac[3:0]], q);
                e_ac = nxt_ac(e_ac, e_inc);
                idle(T_R);
                chk("shift", e_sh, shift);
            end
        end
        op(1'b0, 1'b0, 8'h00);
        idle(0);
        chk("test_mode", 16'h0000, tmode);
        // glyph memory, with a write refused while busy
        e_inc = 1'b1;
        e_scr = 1'b1;
        op(1'b0, 1'b0, 8'h07);
        idle(T_A);
        a = 7'h08 + ($random(seed) & 7'h0f);
        e_ac = a;
        op(1'b0, 1'b0, {3'b010, a[4:0]});
        op(1'b1, 1'b0, 8'h5a);
        idle(T_A);
        chk("glyph_sel", 16'h0001, glyph);
        d = $random(seed);
        e_ac = a + 7'h01;
        op(1'b1, 1'b0, d);
        idle(T_A);
        chk("shift", e_sh, shift);
        e_ac = a;
        op(1'b0, 1'b0, {3'b010, a[4:0]});
        idle(T_A);
        op(1'b1, 1'b1, 8'h00);
        chk("rd_glyph", d[4:0], q[4:0]);
        e_ac = a + 7'h01;
        idle(T_R);
        chk("shift", e_sh, shift);
        for (i = 0; i < 8; i = i + 1) begin
            op(1'b0, 1'b0, 8'h08 | i[7:0]);
            idle(T_A);
            chk("disp_ctrl", i[2:0], {don, con, bon});
        end
        // display shift code: only busy time here, counter untouched
        op(1'b0, 1'b0, 8'h18);
        idle(T_R);
        op(1'b0, 1'b0, 8'h02);
        e_ac = 7'h00;
        e_sh = 4'h0;
        idle(T_A);
        chk("home", 16'h0000, {shift, glyph});
        e_ac = ta;
        op(1'b0, 1'b0, {1'b1, ta});
        idle(T_A);
        op(1'b1, 1'b1, 8'h00);
        chk("rd_home", mem[ta[3:0]], q);
        e_ac = nxt_ac(ta, 1'b1);
        idle(T_R);
        // clear from decrement with scroll on
        op(1'b0, 1'b0, 8'h05);
        idle(T_A);
        op(1'b0, 1'b0, 8'h01);
        e_ac = 7'h00;
        idle(T_C);
        chk("clear_mode", 16'h0003, {inc, scr});
        chk("shift", 16'h0000, shift);
        for (i = 0; i < 16; i = i + 1) begin
            op(1'b1, 1'b1, 8'h00);
            chk("rd_clear", `LID_SPACE_CODE, q);
            e_ac = nxt_ac(e_ac, 1'b1);
            idle(T_R);
        end
        // 4-bit length with a slow host
        #1 is8 = 1'b0;
        host.gap = 9;
        a = $random(seed) & 7'h0f;
        e_ac = a;
        op(1'b0, 1'b0, {1'b1, a});
        idle(T_A);
        d = $random(seed);
        e_ac = nxt_ac(a, 1'b1);
        op(1'b1, 1'b0, d);
        idle(T_A);
        e_ac = a;
        op(1'b0, 1'b0, {1'b1, a});
        idle(T_A);
        op(1'b1, 1'b1, 8'h00);
        chk("rd_4bit", d, q);
        e_ac = nxt_ac(a, 1'b1);
        idle(T_R);
        op(1'b0, 1'b0, 8'h00);
        repeat (4) @(posedge clock);
        chk("test_mode", 16'h0001, tmode);
        end_sim;
    end
endmodule
